// >>> rtl/fault_sev_pkg.sv
// Package: register map, field positions, reset values and severity codes
package fault_sev_pkg;

    // ************************************************************
    // Register bus geometry
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_GROUP  = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_EVENTS = 8'h0C;

    // ************************************************************
    // Control field positions
    // ************************************************************
    localparam int CTRL_ACT_STOP  = 0;  // 1 = Stop for default-stop class
    localparam int CTRL_ACT_RUN   = 1;  // 1 = Stop for default-run class
    localparam int CTRL_OUT_RESET = 2;  // 1 = RESET selected output groups on major failure
    localparam int CTRL_IMMEDIATE = 3;  // 1 = immediate supply detection
    localparam int CTRL_DEBUG     = 4;  // 1 = debug mode
    localparam int CTRL_SMALL_MOD = 5;  // 1 = output module of 32 points or less
    localparam int CTRL_W         = 6;

    // Control reset value: Stop, Run, HOLD, standard, no debug, small module
    localparam logic [5:0] CTRL_RESET  = 6'h21;
    localparam int         GROUP_PTS   = 8;

    // ************************************************************
    // Event bit positions (status and sticky event registers)
    // ************************************************************
    localparam int EV_STOP_CLS = 0;  // Error of default-stop class
    localparam int EV_RUN_CLS  = 1;  // Error of default-run class
    localparam int EV_IO_ERR   = 2;  // Input/output module error
    localparam int EV_SUPPLY   = 3;  // Momentary supply failure
    localparam int EV_LINK     = 4;  // Other minor error
    localparam int EV_CPU      = 5;  // CPU error
    localparam int EV_MEMORY   = 6;  // Memory crash
    localparam int EV_W        = 7;
    localparam int STAT_LVL_LSB = 8; // Severity code in status bits 11:8
    localparam int STAT_INTR    = 12;// Interrupt processing level

    // ************************************************************
    // Severity levels, one-hot
    // ************************************************************
    typedef enum logic [3:0] {
        LVL_NONE     = 4'h1,
        LVL_MINOR    = 4'h2,
        LVL_MODERATE = 4'h4,
        LVL_MAJOR    = 4'h8
    } level_t;

endpackage : fault_sev_pkg

// >>> rtl/sev_if.sv
// Interface between the indicator top and the severity classifier
`timescale 1ns/100ps
`default_nettype none

interface sev_if;
    logic [fault_sev_pkg::EV_W-1:0] events;
    logic                           in_interrupt;
    logic                           act_stop;
    logic                           act_run;
    fault_sev_pkg::level_t          level;
    logic                           supply_minor;

    modport top (output events, output in_interrupt, output act_stop, output act_run,
                 input level, input supply_minor);
    modport cls (input events, input in_interrupt, input act_stop, input act_run,
                 output level, output supply_minor);
endinterface : sev_if

`default_nettype wire

// >>> rtl/sev_classifier.sv
// Severity classifier: sorts active failures into the most severe level
`timescale 1ns/100ps
`default_nettype none

module sev_classifier
(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    // Classification channel
    sev_if.cls        sev
);

    fault_sev_pkg::level_t level_d;
    fault_sev_pkg::level_t level_q;
    logic                  supply_d;
    logic                  supply_q;

    // ************************************************************
    // Classification
    // ************************************************************

    // Per-level sums, then the most severe one wins
    always_comb
    begin
        logic major;
        logic moderate;
        logic minor;
        major    = 1'b0;
        moderate = 1'b0;
        minor    = 1'b0;
        major = sev.events[fault_sev_pkg::EV_CPU] | sev.events[fault_sev_pkg::EV_MEMORY];  // RL11
        if (sev.events[fault_sev_pkg::EV_STOP_CLS])
        begin
            if (sev.act_stop) moderate = 1'b1;  // RL1
            else              minor    = 1'b1;  // RL1
        end
        if (sev.events[fault_sev_pkg::EV_RUN_CLS])
        begin
            if (sev.act_run) moderate = 1'b1;  // RL2
            else             minor    = 1'b1;  // RL2
        end
        // The same module error is tolerated inside interrupt handling
        if (sev.events[fault_sev_pkg::EV_IO_ERR])
        begin
            if (sev.in_interrupt) minor    = 1'b1;  // RL10
            else                  moderate = 1'b1;  // RL10
        end
        if (sev.events[fault_sev_pkg::EV_SUPPLY] | sev.events[fault_sev_pkg::EV_LINK])
        begin
            minor = 1'b1;  // RL8
        end
        if (major)
        begin
            level_d = fault_sev_pkg::LVL_MAJOR;  // RL12
        end
        else if (moderate)
        begin
            level_d = fault_sev_pkg::LVL_MODERATE;  // RL12
        end
        else if (minor)
        begin
            level_d = fault_sev_pkg::LVL_MINOR;
        end
        else
        begin
            level_d = fault_sev_pkg::LVL_NONE;
        end
        supply_d = sev.events[fault_sev_pkg::EV_SUPPLY];
    end

    // Level register
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            level_q  <= fault_sev_pkg::LVL_NONE;
            supply_q <= 1'b0;
        end
        else
        begin
            level_q  <= level_d;
            supply_q <= supply_d;
        end
    end

    assign sev.level        = level_q;
    assign sev.supply_minor = supply_q;

endmodule : sev_classifier

`default_nettype wire

// >>> rtl/fault_severity_indicator.sv
// Fault-severity indicator: lamps, failure contacts, output hold/reset, registers
//
// Functional notes
// [RL1] Default-stop errors: Stop moderate, Run minor; Stop default
// [RL2] Default-run errors: Stop moderate, Run minor; Run default
// [RL3] Standard supply failure: A open, B closed, hold
// [RL4] Immediate supply failure: A closed, ordinary outputs reset
// [RL5] Reset outputs needs small module and RESET
// [RL6] HOLD setting keeps outputs on major/moderate
// [RL7] Moderate: red lamp, program stops, outputs hold
// [RL8] Minor: yellow lamp, program runs, outputs continue
// [RL9] Debug mode also lights the yellow lamp
// [RL10] Module error in interrupt is minor
// [RL11] Major: ready off, A closed, groups configurable
// [RL12] Most severe active level decides everything
`timescale 1ns/100ps
`default_nettype none

module fault_severity_indicator
#(
    parameter int N_GROUPS = 4
)
(
    // Clock and reset
    input  wire logic                              clk_in,
    input  wire logic                              arst_n_in,
    // Register port
    input  wire logic [fault_sev_pkg::ADDR_W-1:0]  reg_addr_in,
    input  wire logic [fault_sev_pkg::DATA_W-1:0]  reg_wdata_in,
    input  wire logic                              reg_wr_in,
    input  wire logic                              reg_rd_in,
    output logic      [fault_sev_pkg::DATA_W-1:0]  reg_rdata_out,
    // Failure detector pins (asynchronous levels)
    input  wire logic [fault_sev_pkg::EV_W-1:0]    fail_events_in,
    input  wire logic                              in_interrupt_in,
    // Lamps
    output logic                                   ready_lamp_out,
    output logic                                   error_lamp_out,
    output logic                                   alarm_lamp_out,
    // Failure contacts, 1 = shorted to common
    output logic                                   fail_contact_a_out,
    output logic                                   fail_contact_b_out,
    // Program and output module control
    output logic                                   program_run_out,
    output logic                                   ord_hold_out,
    output logic      [N_GROUPS-1:0]               ord_reset_group_out,
    output logic                                   adv_hold_out
);

    // ************************************************************
    // Declarations
    // ************************************************************
    // Pin synchroniser stages
    logic [fault_sev_pkg::EV_W-1:0]    ev_s1_q;
    logic [fault_sev_pkg::EV_W-1:0]    ev_s2_q;
    logic                              intr_s1_q;
    logic                              intr_s2_q;

    // Register file state
    logic [fault_sev_pkg::CTRL_W-1:0]  ctrl_d;
    logic [fault_sev_pkg::CTRL_W-1:0]  ctrl_q;
    logic [N_GROUPS-1:0]               group_d;
    logic [N_GROUPS-1:0]               group_q;
    logic [fault_sev_pkg::EV_W-1:0]    sticky_d;
    logic [fault_sev_pkg::EV_W-1:0]    sticky_q;
    logic [fault_sev_pkg::DATA_W-1:0]  rdata_d;

    // Next output values
    logic                              ready_d;
    logic                              error_d;
    logic                              alarm_d;
    logic                              cont_a_d;
    logic                              cont_b_d;
    logic                              run_d;
    logic                              ord_hold_d;
    logic [N_GROUPS-1:0]               ord_reset_d;
    logic                              adv_hold_d;

    // Classifier channel
    sev_if                             sev ();

    // ************************************************************
    // Pin synchronisers
    // ************************************************************

    // Two flops before anything looks at the detector pins
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ev_s1_q   <= '0;
            ev_s2_q   <= '0;
            intr_s1_q <= 1'b0;
            intr_s2_q <= 1'b0;
        end
        else
        begin
            ev_s1_q   <= fail_events_in;
            ev_s2_q   <= ev_s1_q;
            intr_s1_q <= in_interrupt_in;
            intr_s2_q <= intr_s1_q;
        end
    end

    // ************************************************************
    // Severity classification
    // ************************************************************

    // Synced pins and action bits feed it
    assign sev.events       = ev_s2_q;
    assign sev.in_interrupt = intr_s2_q;
    assign sev.act_stop     = ctrl_q[fault_sev_pkg::CTRL_ACT_STOP];  // RL1
    assign sev.act_run      = ctrl_q[fault_sev_pkg::CTRL_ACT_RUN];   // RL2

    // Classifier adds one register stage
    sev_classifier u_classifier
    (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .sev       (sev)
    );

    // ************************************************************
    // Register file
    // ************************************************************

    // Writes, sticky event capture and read mux
    always_comb
    begin
        ctrl_d   = ctrl_q;
        group_d  = group_q;
        rdata_d  = '0;
        sticky_d = sticky_q;

        if (reg_wr_in)
        begin
            if (reg_addr_in == fault_sev_pkg::OFF_CTRL)
            begin
                ctrl_d = reg_wdata_in[fault_sev_pkg::CTRL_W-1:0];
            end
            else if (reg_addr_in == fault_sev_pkg::OFF_GROUP)
            begin
                group_d = reg_wdata_in[N_GROUPS-1:0];
            end
            else if (reg_addr_in == fault_sev_pkg::OFF_EVENTS)
            begin
                sticky_d = sticky_q & ~reg_wdata_in[fault_sev_pkg::EV_W-1:0];
            end
        end

        // Setting after clearing means a new event is never lost
        sticky_d = sticky_d | ev_s2_q;

        // Idle or unmapped reads give zero
        if (reg_rd_in)
        begin
            if (reg_addr_in == fault_sev_pkg::OFF_CTRL)
            begin
                rdata_d[fault_sev_pkg::CTRL_W-1:0] = ctrl_q;
            end
            else if (reg_addr_in == fault_sev_pkg::OFF_GROUP)
            begin
                rdata_d[N_GROUPS-1:0] = group_q;
            end
            else if (reg_addr_in == fault_sev_pkg::OFF_STATUS)
            begin
                rdata_d[fault_sev_pkg::EV_W-1:0] = ev_s2_q;
                rdata_d[fault_sev_pkg::STAT_LVL_LSB +: 4] = sev.level;
                rdata_d[fault_sev_pkg::STAT_INTR] = intr_s2_q;
            end
            else if (reg_addr_in == fault_sev_pkg::OFF_EVENTS)
            begin
                rdata_d[fault_sev_pkg::EV_W-1:0] = sticky_q;
            end
        end
    end

    // Register state
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ctrl_q        <= fault_sev_pkg::CTRL_RESET;  // RL1 RL2
            group_q       <= '0;
            sticky_q      <= '0;
            reg_rdata_out <= '0;
        end
        else
        begin
            ctrl_q        <= ctrl_d;
            group_q       <= group_d;
            sticky_q      <= sticky_d;
            reg_rdata_out <= rdata_d;
        end
    end

    // ************************************************************
    // Indicator and contact decode
    // ************************************************************

    // Each level drives lamps, contacts and output handling
    always_comb
    begin
        logic out_reset_ok;
        // Small modules only may drop points on a major failure
        out_reset_ok = ctrl_q[fault_sev_pkg::CTRL_OUT_RESET] & ctrl_q[fault_sev_pkg::CTRL_SMALL_MOD];  // RL5 RL6

        ready_d     = 1'b1;
        error_d     = 1'b0;
        alarm_d     = ctrl_q[fault_sev_pkg::CTRL_DEBUG];  // RL9

        cont_a_d    = 1'b1;
        cont_b_d    = 1'b0;
        run_d       = 1'b1;
        ord_hold_d  = 1'b0;
        ord_reset_d = '0;
        adv_hold_d  = 1'b0;

        case (sev.level)
            fault_sev_pkg::LVL_MAJOR:
            begin
                ready_d     = 1'b0;  // RL11
                run_d       = 1'b0;
                cont_a_d    = 1'b1;  // RL11
                cont_b_d    = 1'b0;  // RL11
                ord_hold_d  = 1'b1;  // RL11
                ord_reset_d = out_reset_ok ? group_q : '0;  // RL5 RL6 RL11
                adv_hold_d  = 1'b1;  // RL11
            end
            fault_sev_pkg::LVL_MODERATE:
            begin
                // Held regardless of setting
                error_d    = 1'b1;  // RL7
                run_d      = 1'b0;  // RL7
                cont_a_d   = 1'b0;  // RL7
                cont_b_d   = 1'b1;  // RL7
                ord_hold_d = 1'b1;  // RL7
                adv_hold_d = 1'b1;  // RL7
            end
            fault_sev_pkg::LVL_MINOR:
            begin
                alarm_d  = 1'b1;  // RL8
                cont_a_d = 1'b0;  // RL8
                cont_b_d = 1'b1;  // RL8

                // Supply dip overrides the free-running minor outputs
                if (sev.supply_minor)
                begin
                    adv_hold_d = 1'b1;  // RL3 RL4
                    if (ctrl_q[fault_sev_pkg::CTRL_IMMEDIATE])
                    begin
                        cont_a_d    = 1'b1;  // RL4
                        cont_b_d    = 1'b0;  // RL4
                        ord_reset_d = '1;    // RL4
                    end
                    else
                    begin
                        ord_hold_d = 1'b1;  // RL3
                    end
                end
            end
            default:
            begin
                cont_a_d = 1'b0;
                cont_b_d = 1'b1;
            end
        endcase
    end

    // Output flops keep every pin glitch free
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ready_lamp_out      <= 1'b1;
            error_lamp_out      <= 1'b0;
            alarm_lamp_out      <= 1'b0;
            fail_contact_a_out  <= 1'b0;
            fail_contact_b_out  <= 1'b1;
            program_run_out     <= 1'b1;
            ord_hold_out        <= 1'b0;
            ord_reset_group_out <= '0;
            adv_hold_out        <= 1'b0;
        end
        else
        begin
            ready_lamp_out      <= ready_d;
            error_lamp_out      <= error_d;
            alarm_lamp_out      <= alarm_d;
            fail_contact_a_out  <= cont_a_d;
            fail_contact_b_out  <= cont_b_d;
            program_run_out     <= run_d;
            ord_hold_out        <= ord_hold_d;
            ord_reset_group_out <= ord_reset_d;
            adv_hold_out        <= adv_hold_d;
        end
    end

endmodule : fault_severity_indicator

`default_nettype wire

// >>> sim/fault_severity_indicator_chk.sv
// Checker: port-level assertions for the fault severity indicator
`timescale 1ns/100ps
`default_nettype none
module fault_severity_indicator_chk
#(
    parameter int N_GROUPS = 4
)
(
    // Clock and reset
    input wire logic                               clk_in,
    input wire logic                               arst_n_in,
    // Register read path
    input wire logic                               reg_rd_in,
    input wire logic [fault_sev_pkg::DATA_W-1:0]   reg_rdata_out,
    // Failure pins
    input wire logic [fault_sev_pkg::EV_W-1:0]     fail_events_in,
    input wire logic                               in_interrupt_in,
    // Indicator and output control
    input wire logic                               ready_lamp_out,
    input wire logic                               error_lamp_out,
    input wire logic                               alarm_lamp_out,
    input wire logic                               fail_contact_a_out,
    input wire logic                               fail_contact_b_out,
    input wire logic                               program_run_out,
    input wire logic                               ord_hold_out,
    input wire logic [N_GROUPS-1:0]                ord_reset_group_out,
    input wire logic                               adv_hold_out
);
    // ****************************************
    // Assertions, pin levels held 5 edges cover the 4-edge path
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    major_outputs_a: assert property (
        (|fail_events_in[6:5]) [*5] |-> !ready_lamp_out && !error_lamp_out
        && fail_contact_a_out && !fail_contact_b_out && !program_run_out)
        else $error("major failure outputs wrong");
    moderate_io_a: assert property (
        (fail_events_in[6:2] == 5'h01 && !in_interrupt_in) [*5] |-> error_lamp_out
        && !program_run_out && !fail_contact_a_out && ord_hold_out && adv_hold_out)
        else $error("module error outside interrupt not moderate");
    minor_intr_a: assert property (
        (fail_events_in == 7'h04 && in_interrupt_in) [*5] |-> alarm_lamp_out
        && program_run_out && !error_lamp_out && !fail_contact_a_out && !ord_hold_out)
        else $error("module error in interrupt not minor");
    idle_state_a: assert property (
        (fail_events_in == 7'h00) [*5] |-> ready_lamp_out && !error_lamp_out
        && !fail_contact_a_out && program_run_out)
        else $error("idle outputs wrong");
    contacts_opposed_a: assert property (
        fail_contact_a_out != fail_contact_b_out)
        else $error("failure contacts not complementary");
    error_stops_a: assert property (
        (error_lamp_out || !ready_lamp_out) |-> !program_run_out)
        else $error("program runs during failure");
    group_reset_a: assert property (
        (|ord_reset_group_out) |-> fail_contact_a_out && adv_hold_out)
        else $error("group reset without contact or advanced hold");
    read_idle_a: assert property (
        !$past(reg_rd_in) |-> reg_rdata_out == '0)
        else $error("read data outside read cycle");
endmodule : fault_severity_indicator_chk

bind fault_severity_indicator fault_severity_indicator_chk #(.N_GROUPS(N_GROUPS)) chk_i
(
    .clk_in, .arst_n_in, .reg_rd_in, .reg_rdata_out, .fail_events_in, .in_interrupt_in,
    .ready_lamp_out, .error_lamp_out, .alarm_lamp_out, .fail_contact_a_out,
    .fail_contact_b_out, .program_run_out, .ord_hold_out, .ord_reset_group_out, .adv_hold_out
);
`default_nettype wire

// >>> sim/plant_model.sv
// Plant model: failure detectors and an ordinary output module image
`timescale 1ns/100ps
`default_nettype none
module plant_model
#(
    parameter int N_GROUPS = 4
)
(
    // Clock and bench commands
    input  wire logic                             clk_in,
    input  wire logic [fault_sev_pkg::EV_W-1:0]   cmd_events_in,
    input  wire logic                             cmd_intr_in,
    input  wire logic [N_GROUPS*8-1:0]            prog_val_in,
    // Output module control from the block
    input  wire logic                             ord_hold_in,
    input  wire logic [N_GROUPS-1:0]              ord_reset_group_in,
    // Detector pins and output points
    output logic      [fault_sev_pkg::EV_W-1:0]   fail_events_out,
    output logic                                  in_interrupt_out,
    output logic      [N_GROUPS*8-1:0]            points_out
);
    // ****************************************
    // Detectors and points
    // ****************************************
    // Detectors are plain levels, so they pass straight through
    assign fail_events_out  = cmd_events_in;
    assign in_interrupt_out = cmd_intr_in;
    // A reset group clears; a held module ignores the program
    always_ff @(posedge clk_in)
    begin
        for (int g = 0; g < N_GROUPS; g++)
        begin
            if (ord_reset_group_in[g])
                points_out[g*8 +: 8] <= 8'h00;
            else if (!ord_hold_in)
                points_out[g*8 +: 8] <= prog_val_in[g*8 +: 8];
        end
    end
endmodule : plant_model
`default_nettype wire

// >>> sim/tb_fault_severity_indicator.sv
// Testbench: directed scenarios for the fault severity indicator
`timescale 1ns/100ps
`default_nettype none
module tb_fault_severity_indicator;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic        clk_in = 1'b0;
    logic        arst_n_in, reg_wr_in, reg_rd_in, in_interrupt_in, cmd_intr;
    logic [7:0]  reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, points;
    logic [6:0]  fail_events_in, cmd_ev;
    logic        ready_lamp_out, error_lamp_out, alarm_lamp_out, program_run_out;
    logic        fail_contact_a_out, fail_contact_b_out, ord_hold_out, adv_hold_out;
    logic [3:0]  ord_reset_group_out;
    logic [11:0] outs;
    int          err_count, samples_checked;

    // Outputs packed as ready,error,alarm,a,b,run,hold,groups,adv
    assign outs = {ready_lamp_out, error_lamp_out, alarm_lamp_out, fail_contact_a_out,
                   fail_contact_b_out, program_run_out, ord_hold_out, ord_reset_group_out,
                   adv_hold_out};

    fault_severity_indicator #(.N_GROUPS(4)) dut
    (
        .clk_in, .arst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .fail_events_in, .in_interrupt_in, .ready_lamp_out,
        .error_lamp_out, .alarm_lamp_out, .fail_contact_a_out, .fail_contact_b_out,
        .program_run_out, .ord_hold_out, .ord_reset_group_out, .adv_hold_out
    );
    plant_model #(.N_GROUPS(4)) plant
    (
        .clk_in, .cmd_events_in(cmd_ev), .cmd_intr_in(cmd_intr),
        .prog_val_in(32'hA5A5A5A5), .ord_hold_in(ord_hold_out),
        .ord_reset_group_in(ord_reset_group_out), .fail_events_out(fail_events_in),
        .in_interrupt_out(in_interrupt_in), .points_out(points)
    );

    always #20 clk_in = ~clk_in;

    // ****************************************
    // Shared tasks
    // ****************************************
    task check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task finish_test;
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge clk_in);
        reg_wr_in    <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clk_in);
        reg_rd_in   <= 1'b0;
        #1;
        check(reg_rdata_out, exp);
    endtask : rd_chk

    task set_pins(input logic [6:0] e, input logic i);
        @(posedge clk_in);
        cmd_ev   <= e;
        cmd_intr <= i;
    endtask : set_pins

    // Pin to output takes 4 edges; one spare edge for margin
    task settle_chk(input logic [11:0] exp);
        repeat (5) @(posedge clk_in);
        #1;
        check(outs, exp);
    endtask : settle_chk

    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset;
        #1;
        check(outs, 12'h8C0);
        rd_chk(8'h00, 32'h21);
        rd_chk(8'h04, 32'h0);
        rd_chk(8'h10, 32'h0);
        wr_reg(8'h08, 32'hFFFFFFFF);
        rd_chk(8'h08, 32'h100);
    endtask : t_reset

    task t_classes;
        set_pins(7'h01, 1'b0);
        settle_chk(12'hCA1);
        wr_reg(8'h00, 32'h20);
        settle_chk(12'hAC0);
        wr_reg(8'h00, 32'h21);
        set_pins(7'h02, 1'b0);
        settle_chk(12'hAC0);
        wr_reg(8'h00, 32'h23);
        settle_chk(12'hCA1);
        wr_reg(8'h00, 32'h21);
        set_pins(7'h00, 1'b0);
    endtask : t_classes

    task t_supply;
        set_pins(7'h08, 1'b0);
        settle_chk(12'hAE1);
        wr_reg(8'h00, 32'h29);
        settle_chk(12'hB5F);
        wr_reg(8'h00, 32'h21);
        set_pins(7'h00, 1'b0);
    endtask : t_supply

    task t_major;
        wr_reg(8'h04, 32'h5);
        wr_reg(8'h00, 32'h25);
        set_pins(7'h20, 1'b0);
        settle_chk(12'h12B);
        check(points, 32'hA500A500);
        rd_chk(8'h08, 32'h820);
        wr_reg(8'h00, 32'h05);
        settle_chk(12'h121);
        wr_reg(8'h00, 32'h21);
        set_pins(7'h40, 1'b0);
        settle_chk(12'h121);
        wr_reg(8'h00, 32'h25);
        set_pins(7'h01, 1'b0);
        settle_chk(12'hCA1);
        wr_reg(8'h00, 32'h21);
        wr_reg(8'h04, 32'h0);
        set_pins(7'h00, 1'b0);
    endtask : t_major

    task t_debug_io;
        wr_reg(8'h00, 32'h31);
        settle_chk(12'hAC0);
        wr_reg(8'h00, 32'h21);
        settle_chk(12'h8C0);
        set_pins(7'h04, 1'b1);
        settle_chk(12'hAC0);
        rd_chk(8'h08, 32'h1204);
        set_pins(7'h04, 1'b0);
        settle_chk(12'hCA1);
        set_pins(7'h00, 1'b0);
    endtask : t_debug_io

    task t_priority;
        settle_chk(12'h8C0);
        wr_reg(8'h0C, 32'h7F);
        set_pins(7'h49, 1'b0);
        settle_chk(12'h121);
        set_pins(7'h09, 1'b0);
        settle_chk(12'hCA1);
        set_pins(7'h08, 1'b0);
        settle_chk(12'hAE1);
        set_pins(7'h00, 1'b0);
        settle_chk(12'h8C0);
        rd_chk(8'h0C, 32'h49);
        wr_reg(8'h0C, 32'h7F);
        rd_chk(8'h0C, 32'h0);
    endtask : t_priority

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial
    begin
        err_count       = 0;
        samples_checked = 0;
        arst_n_in       = 1'b0;
        reg_addr_in     = 8'h00;
        reg_wdata_in    = 32'h0;
        reg_wr_in       = 1'b0;
        reg_rd_in       = 1'b0;
        cmd_ev          = 7'h00;
        cmd_intr        = 1'b0;
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        t_reset();
        t_classes();
        t_supply();
        t_major();
        t_debug_io();
        t_priority();
        finish_test();
    end

    // Run needs under two hundred cycles; this limit is ample
    initial
    begin
        repeat (5000) @(posedge clk_in);
        err_count++;
        finish_test();
    end
endmodule : tb_fault_severity_indicator
`default_nettype wire
